// ===== src/rfa_outputs.sv
// Run and frequency arrival output logic with terminal routing
`timescale 1ns/100ps
`default_nettype none
module rfa_outputs
  import rfa_pkg::*;
#(
  parameter int unsigned P_ARRIVE_DLY_CYC = ARRIVE_DLY_CYC
) (
  input  wire logic       i_clk_sys,
  input  wire logic       i_rst_b,
  input  wire logic       i_ce,
  input  wire rfa_drive_s i_drive,
  input  wire rfa_freq_t  i_out_freq,
  input  wire rfa_param_s i_param,
  input  wire logic [7:0] i_term11_sel,
  input  wire logic [7:0] i_relay_function_select,
  input  wire logic       i_term11_ext_act,
  input  wire logic       i_relay_ext_act,
  output rfa_stat_s       o_stat,
  output logic            o_term11_out,
  output logic            o_term11_oe,
  output logic            o_relay_coil
);

  logic      ramp;
  rfa_freq_t csa_on_margin;
  rfa_freq_t csa_off_margin;
  rfa_freq_t csa_dist;
  logic      csa_set;
  logic      csa_clr;
  logic      ofa_set;
  logic      ofa_clr;
  logic      csa_raw;
  logic      ofa_raw;
  logic      csa_dly;
  logic      ofa_dly;
  logic      run_ff;
  logic      term11_oe_ff;
  logic      relay_coil_ff;
  rfa_stat_s stat_ff;
  logic      nxt_term11_act;
  logic      nxt_relay_act;

  // Frequency plus offset at or above threshold, one bit wider
  function automatic logic rfa_reach(input rfa_freq_t       f,
                                     input logic [FREQ_W:0] ofs,
                                     input rfa_freq_t       thr);
    return ({1'b0, f} + ofs) >= {1'b0, thr};
  endfunction

  // Level of one function code for a terminal [R12] [R15]
  function automatic logic rfa_route(input logic [7:0] sel,
                                     input logic       run_lvl,
                                     input logic       csa_lvl,
                                     input logic       ofa_lvl,
                                     input logic       ext_lvl);
    logic act;
    unique case (sel)
      FN_RUN:  act = run_lvl;
      FN_CSA:  act = csa_lvl;
      FN_OFA:  act = ofa_lvl;
      default: act = ext_lvl;
    endcase
    return act;
  endfunction

  assign ramp = i_drive.accel | i_drive.decel;

  // Margins from maximum frequency, distance to set frequency [R07] [R08]
  assign csa_on_margin  = rfa_pct_of(i_param.max_freq, CSA_ON_PCT);
  assign csa_off_margin = rfa_pct_of(i_param.max_freq, CSA_OFF_PCT);
  assign csa_dist = rfa_abs_diff(i_out_freq, i_param.set_frequency_param);

  // Constant speed arrival window [R03] [R04] [R08]
  assign csa_set = i_drive.run & ~ramp & (csa_dist <= csa_on_margin);
  assign csa_clr = ~i_drive.run | ramp | (csa_dist > csa_off_margin);

  // Over frequency: on early while not decelerating [R05] [R09] [R11]
  assign ofa_set = i_drive.run & ~i_drive.decel &
                   rfa_reach(i_out_freq, OFA_ANTIC_DHZ,
                             i_param.accel_on_threshold);
  // Off with lag while decelerating, or when stopped [R06] [R09] [R11]
  // Thresholds are independent, so equal values are legal [R13]
  assign ofa_clr = ~i_drive.run |
                   (i_drive.decel &
                    ~rfa_reach(i_out_freq, OFA_LAG_DHZ,
                               i_param.decel_off_threshold));

  rfa_hyst u_csa_hyst (
    .i_clk_sys (i_clk_sys),
    .i_rst_b   (i_rst_b),
    .i_ce      (i_ce),
    .i_set     (csa_set),
    .i_clr     (csa_clr),
    .o_state   (csa_raw)
  );

  rfa_hyst u_ofa_hyst (
    .i_clk_sys (i_clk_sys),
    .i_rst_b   (i_rst_b),
    .i_ce      (i_ce),
    .i_set     (ofa_set),
    .i_clr     (ofa_clr),
    .o_state   (ofa_raw)
  );

  rfa_delay #(
    .P_DLY_CYC (P_ARRIVE_DLY_CYC)
  ) u_csa_delay (
    .i_clk_sys (i_clk_sys),
    .i_rst_b   (i_rst_b),
    .i_ce      (i_ce),
    .i_raw     (csa_raw),
    .o_dly     (csa_dly)
  );

  rfa_delay #(
    .P_DLY_CYC (P_ARRIVE_DLY_CYC)
  ) u_ofa_delay (
    .i_clk_sys (i_clk_sys),
    .i_rst_b   (i_rst_b),
    .i_ce      (i_ce),
    .i_raw     (ofa_raw),
    .o_dly     (ofa_dly)
  );

  // Run indication follows drive run state [R01]
  always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
    if (!i_rst_b) begin
      run_ff <= 1'b0;
    end else if (i_ce) begin
      run_ff <= i_drive.run;
    end
  end

  // Function selection for each terminal [R12] [R15]
  always_comb begin
    nxt_term11_act = rfa_route(i_term11_sel, run_ff, csa_dly, ofa_dly,
                               i_term11_ext_act);
    nxt_relay_act  = rfa_route(i_relay_function_select, run_ff, csa_dly,
                               ofa_dly, i_relay_ext_act);
  end

  // Open collector pulls low while active [R02] [R14]
  always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
    if (!i_rst_b) begin
      term11_oe_ff <= 1'b0;
    end else if (i_ce) begin
      term11_oe_ff <= nxt_term11_act;
    end
  end

  // Relay coil energised while active [R15]
  always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
    if (!i_rst_b) begin
      relay_coil_ff <= 1'b0;
    end else if (i_ce) begin
      relay_coil_ff <= nxt_relay_act;
    end
  end

  // Active low status copies [R02] [R14]
  always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
    if (!i_rst_b) begin
      stat_ff <= '1;
    end else if (i_ce) begin
      stat_ff.run_b                 <= ~run_ff;
      stat_ff.const_speed_arrival_b <= ~csa_dly;
      stat_ff.over_freq_arrival_b   <= ~ofa_dly;
    end
  end

  assign o_stat       = stat_ff;
  assign o_term11_out = 1'b0;
  assign o_term11_oe  = term11_oe_ff;
  assign o_relay_coil = relay_coil_ff;

  // Checks
  default clocking cb @(posedge i_clk_sys);
  endclocking
  default disable iff (!i_rst_b);

  a_run_follow: assert property ( // [R01]
    i_ce ##1 i_ce |=> o_stat.run_b == !$past(i_drive.run, 2))
    else $error("run status does not follow drive state");

  a_csa_ramp_off: assert property ( // [R04]
    i_ce && i_drive.run && ramp |=> !csa_raw)
    else $error("constant speed arrival raw on during ramp");

  a_csa_on_win: assert property ( // [R08]
    i_ce && i_drive.run && !ramp && csa_dist <= csa_on_margin |=> csa_raw)
    else $error("constant speed arrival not on inside window");

  a_csa_off_win: assert property ( // [R08]
    i_ce && csa_dist > csa_off_margin |=> !csa_raw)
    else $error("constant speed arrival not off beyond window");

  a_csa_hold_band: assert property ( // [R08]
    i_ce && csa_raw && i_drive.run && !ramp &&
    csa_dist <= csa_off_margin |=> csa_raw)
    else $error("constant speed arrival dropped inside hysteresis band");

  a_ofa_on_acc: assert property ( // [R09]
    i_ce && i_drive.run && i_drive.accel &&
    ({1'b0, i_out_freq} + OFA_ANTIC_DHZ) >=
    {1'b0, i_param.accel_on_threshold} |=> ofa_raw)
    else $error("over frequency arrival not on at early threshold");

  a_ofa_off_dec: assert property ( // [R11]
    i_ce && i_drive.decel &&
    ({1'b0, i_out_freq} + OFA_LAG_DHZ) <
    {1'b0, i_param.decel_off_threshold} |=> !ofa_raw)
    else $error("over frequency arrival not off below decel threshold");

  a_ofa_hold_dec: assert property ( // [R09]
    i_ce && ofa_raw && i_drive.run && i_drive.decel &&
    ({1'b0, i_out_freq} + OFA_LAG_DHZ) >=
    {1'b0, i_param.decel_off_threshold} |=> ofa_raw)
    else $error("over frequency arrival dropped before lagged threshold");

  a_arr_stop_off: assert property ( // [R06]
    i_ce && !i_drive.run |=> !ofa_raw && !csa_raw)
    else $error("arrival raw on while stopped");

  a_dly_settled: assert property ( // [R10]
    i_ce && $changed(csa_raw) |=> $stable(csa_dly))
    else $error("arrival delay passed a change at once");

  a_dly_follows: assert property ( // [R16]
    $changed(ofa_dly) |-> $past(ofa_raw) == ofa_dly)
    else $error("delayed arrival took a level raw did not hold");

  a_term_route: assert property ( // [R12]
    i_ce && i_term11_sel == FN_CSA |=> o_term11_oe == $past(csa_dly))
    else $error("terminal does not carry constant speed arrival");

  a_relay_route: assert property ( // [R15]
    i_ce && i_relay_function_select == FN_RUN |=>
    o_relay_coil == $past(run_ff))
    else $error("relay does not carry run indication");

  a_oc_low: assert property ( // [R14]
    o_term11_out == 1'b0)
    else $error("open collector data not low");

  a_term_run_low: assert property ( // [R02]
    i_ce && i_term11_sel == FN_RUN |=> o_term11_oe == !o_stat.run_b)
    else $error("terminal and status disagree on run indication");

  a_csa_stat_low: assert property ( // [R14]
    i_ce |=> o_stat.const_speed_arrival_b == !$past(csa_dly))
    else $error("constant speed status is not the inverse of arrival");

  a_ofa_stat_low: assert property ( // [R14]
    i_ce |=> o_stat.over_freq_arrival_b == !$past(ofa_dly))
    else $error("over frequency status is not the inverse of arrival");

  a_ofa_hold_run: assert property ( // [R05]
    i_ce && ofa_raw && i_drive.run && !i_drive.decel |=> ofa_raw)
    else $error("over frequency arrival dropped outside deceleration");

  a_dec_no_set: assert property ( // [R11]
    i_ce && !ofa_raw && i_drive.decel |=> !ofa_raw)
    else $error("over frequency arrival turned on while decelerating");

  a_relay_ext: assert property ( // [R15]
    i_ce && i_relay_function_select > FN_OFA |=>
    o_relay_coil == $past(i_relay_ext_act))
    else $error("relay does not carry the external function");

  a_relay_ofa: assert property ( // [R12]
    i_ce && i_relay_function_select == FN_OFA |=>
    o_relay_coil == $past(ofa_dly))
    else $error("relay does not carry over frequency arrival");

  a_term_ext: assert property ( // [R12]
    i_ce && i_term11_sel > FN_OFA |=>
    o_term11_oe == $past(i_term11_ext_act))
    else $error("terminal does not carry the external function");

  a_run_relay_low: assert property ( // [R15]
    i_ce && i_relay_function_select == FN_RUN |=>
    o_relay_coil == !o_stat.run_b)
    else $error("relay and status disagree on run indication");

  a_dly_frozen: assert property ( // [R16]
    !i_ce |=> $stable(csa_dly) && $stable(ofa_dly))
    else $error("arrival delay moved while clock enable low");

  a_run_frozen: assert property ( // [R01]
    !i_ce |=> $stable(o_stat) && $stable(o_relay_coil))
    else $error("outputs moved while clock enable low");

  c_run_relay: cover property (
    i_relay_function_select == FN_RUN && $rose(o_relay_coil));

  c_csa_rise: cover property ($fell(o_stat.const_speed_arrival_b));

  c_ofa_rise: cover property ($fell(o_stat.over_freq_arrival_b));

  c_both_assigned: cover property (
    i_term11_sel == FN_CSA && i_relay_function_select == FN_OFA &&
    o_term11_oe && o_relay_coil);

  c_csa_filtered: cover property (
    $fell(csa_raw) ##1 !csa_raw [*2] ##1 csa_raw && csa_dly);

endmodule
`default_nettype wire

// ===== src/rfa_pkg.sv
// Constants, types and helpers for the run and frequency arrival outputs
// Behaviour
// (R01) Run output follows run and stop state
// (R02) Run indication is active low
// (R03) Code 01 asserts constant speed arrival
// (R04) Constant speed arrival off when stopped or ramping
// (R05) Code 02 asserts over frequency arrival, ramps too
// (R06) Over frequency off when stopped or below threshold
// (R07) Constant speed target is set frequency parameter
// (R08) On within 1 percent, off beyond 2 percent
// (R09) Anticipate on by 1.5 Hz, lag off 0.5 Hz
// (R10) Arrival outputs change after 60 ms delay
// (R11) Accel threshold turns on, decel threshold off
// (R12) Both arrival functions may use both terminals
// (R13) Equal accel and decel thresholds are accepted
// (R14) Arrival outputs are active low
// (R15) Relay code 00 routes run indication
// (R16) Delay counter restarts when raw condition changes
`default_nettype none
package rfa_pkg;

  // Frequencies in steps of 0.1 Hz
  localparam int unsigned FREQ_W = 16;
  typedef logic [FREQ_W-1:0] rfa_freq_t;

  localparam int unsigned PROD_W = 24;
  localparam logic [7:0] CSA_ON_PCT = 8'h01;
  localparam logic [7:0] CSA_OFF_PCT = 8'h02;
  localparam logic [PROD_W-1:0] PCT_DIV = 24'h000064;

  // 1.5 Hz and 0.5 Hz in 0.1 Hz steps
  localparam logic [FREQ_W:0] OFA_ANTIC_DHZ = 17'h0000f;
  localparam logic [FREQ_W:0] OFA_LAG_DHZ = 17'h00005;

  // Function codes for output selection
  localparam logic [7:0] FN_RUN = 8'h00;
  localparam logic [7:0] FN_CSA = 8'h01;
  localparam logic [7:0] FN_OFA = 8'h02;

  // Arrival delay
  localparam int unsigned CLK_HZ = 100_000_000;
  localparam int unsigned ARRIVE_DLY_MS = 60;
  localparam int unsigned ARRIVE_DLY_CYC = ARRIVE_DLY_MS * (CLK_HZ / 1000);
  localparam int unsigned DLY_CNT_W = 23;

  typedef struct packed {
    logic run;
    logic accel;
    logic decel;
  } rfa_drive_s;

  typedef struct packed {
    rfa_freq_t set_frequency_param;
    rfa_freq_t max_freq;
    rfa_freq_t accel_on_threshold;
    rfa_freq_t decel_off_threshold;
  } rfa_param_s;

  typedef struct packed {
    logic run_b;
    logic const_speed_arrival_b;
    logic over_freq_arrival_b;
  } rfa_stat_s;

  function automatic rfa_freq_t rfa_pct_of(input rfa_freq_t m,
                                           input logic [7:0] p);
    logic [PROD_W-1:0] prod;
    prod = PROD_W'(m) * PROD_W'(p);
    return FREQ_W'(prod / PCT_DIV);
  endfunction

  function automatic rfa_freq_t rfa_abs_diff(input rfa_freq_t a,
                                             input rfa_freq_t b);
    return (a >= b) ? (a - b) : (b - a);
  endfunction

endpackage
`default_nettype wire

// ===== src/rfa_hyst.sv
// Set and clear hysteresis latch, clear has priority
`timescale 1ns/100ps
`default_nettype none
module rfa_hyst
  import rfa_pkg::*;
(
  input  wire logic i_clk_sys,
  input  wire logic i_rst_b,
  input  wire logic i_ce,
  input  wire logic i_set,
  input  wire logic i_clr,
  output logic      o_state
);

  logic state_ff;

  always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
    if (!i_rst_b) begin
      state_ff <= 1'b0;
    end else if (i_ce) begin
      if (i_clr) begin
        state_ff <= 1'b0;
      end else if (i_set) begin
        state_ff <= 1'b1;
      end
    end
  end

  assign o_state = state_ff;

endmodule
`default_nettype wire

// ===== src/rfa_delay.sv
// Change delay filter for one arrival signal
`timescale 1ns/100ps
`default_nettype none
module rfa_delay
  import rfa_pkg::*;
#(
  parameter int unsigned P_DLY_CYC = ARRIVE_DLY_CYC
) (
  input  wire logic                 i_clk_sys,
  input  wire logic                 i_rst_b,
  input  wire logic                 i_ce,
  input  wire logic                 i_raw,
  output logic                      o_dly
);

  localparam logic [DLY_CNT_W-1:0] CNT_LAST = DLY_CNT_W'(P_DLY_CYC - 1);

  logic                 dly_ff;
  logic [DLY_CNT_W-1:0] cnt_ff;

  // Count only while raw differs; a return restarts the wait [R16]
  always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
    if (!i_rst_b) begin
      cnt_ff <= '0;
    end else if (i_ce) begin
      if (i_raw == dly_ff || cnt_ff == CNT_LAST) begin
        cnt_ff <= '0;
      end else begin
        cnt_ff <= cnt_ff + 1'b1;
      end
    end
  end

  // Take the new level once the wait is over [R10]
  always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
    if (!i_rst_b) begin
      dly_ff <= 1'b0;
    end else if (i_ce) begin
      if (i_raw != dly_ff && cnt_ff == CNT_LAST) begin
        dly_ff <= i_raw;
      end
    end
  end

  assign o_dly = dly_ff;

endmodule
`default_nettype wire

// ===== bench/rfa_ext_equip.sv
// Model of external equipment reading the output terminals
`timescale 1ns/100ps
`default_nettype none
module rfa_ext_equip (
  input  wire logic i_term11_out,
  input  wire logic i_term11_oe,
  input  wire logic i_relay_coil,
  output logic      o_term11_lvl,
  output logic      o_relay_no_closed
);
  // Pull-up holds the line high while the transistor is off
  assign o_term11_lvl = i_term11_oe ? i_term11_out : 1'b1;
  // Normally open contact closes with the coil
  assign o_relay_no_closed = i_relay_coil;
endmodule
`default_nettype wire

// ===== bench/rfa_outputs_tb_top.sv
// Testbench for the run and frequency arrival outputs
`timescale 1ns/100ps
`default_nettype none
module rfa_outputs_tb_top;
  import rfa_pkg::*;
  localparam int unsigned P = 4;
  localparam rfa_drive_s STP = 3'b000;
  localparam rfa_drive_s RUNS = 3'b100;
  localparam rfa_drive_s ACC = 3'b110;
  localparam rfa_drive_s DEC = 3'b101;
  logic       i_clk_sys = 1'b0;
  logic       i_rst_b = 1'b0;
  logic       ce = 1'b1;
  rfa_drive_s drive = STP;
  rfa_freq_t  freq = 16'h0000;
  rfa_param_s prm = {16'h01f4, 16'h03e8, 16'h012c, 16'h00c8};
  logic [7:0] tsel = 8'h00;
  logic [7:0] rsel = 8'h00;
  logic       text = 1'b0;
  logic       rext = 1'b0;
  rfa_stat_s  stat;
  logic       tout;
  logic       toe;
  logic       coil;
  logic       lvl;
  logic       no;
  int         fail_count = 0;
  int         tests_run = 0;
  int         cyc = 0;

  rfa_outputs #(.P_ARRIVE_DLY_CYC(P)) rfa_outputs_i (
    .i_clk_sys(i_clk_sys), .i_rst_b(i_rst_b), .i_ce(ce),
    .i_drive(drive), .i_out_freq(freq), .i_param(prm),
    .i_term11_sel(tsel), .i_relay_function_select(rsel),
    .i_term11_ext_act(text), .i_relay_ext_act(rext),
    .o_stat(stat), .o_term11_out(tout), .o_term11_oe(toe),
    .o_relay_coil(coil)
  );
  rfa_ext_equip rfa_ext_equip_i (
    .i_term11_out(tout), .i_term11_oe(toe), .i_relay_coil(coil),
    .o_term11_lvl(lvl), .o_relay_no_closed(no)
  );

  always #5 i_clk_sys = ~i_clk_sys;

  task stop_test;
    $display("Checks %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  always @(posedge i_clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 2000) begin
      fail_count++;
      stop_test();
    end
  end

  task chk(input string n, input logic e, input logic g);
    tests_run++;
    if (g !== e) begin
      fail_count++;
      $display("[ERR] %s exp %b got %b", n, e, g);
    end
  endtask

  task wcyc(input int n);
    repeat (n) @(negedge i_clk_sys);
  endtask

  // Apply a drive state and frequency, then let the delay run out
  task go(input rfa_drive_s d, input rfa_freq_t f);
    @(negedge i_clk_sys);
    drive = d;
    freq = f;
    wcyc(P + 4);
  endtask

  // Terminal 11 carries constant speed, relay carries over frequency
  task arr(input logic e1, input logic e2);
    chk("csa_b", ~e1, stat.const_speed_arrival_b);
    chk("ofa_b", ~e2, stat.over_freq_arrival_b);
    chk("term11_lvl", ~e1, lvl);
    chk("relay_no", e2, no);
  endtask

  initial begin
    wcyc(6);
    chk("stat_rst", 1'b1, &stat);
    chk("oe_rst", 1'b0, toe);
    i_rst_b = 1'b1;
    go(RUNS, 16'h0000);
    chk("run_b", 1'b0, stat.run_b);
    chk("term11_lvl", 1'b0, lvl);
    chk("relay_no", 1'b1, no);
    go(STP, 16'h0000);
    chk("run_b", 1'b1, stat.run_b);
    chk("term11_lvl", 1'b1, lvl);
    chk("relay_no", 1'b0, no);
    // Frozen while clock enable is low
    ce = 1'b0;
    drive = RUNS;
    wcyc(5);
    chk("run_b_frz", 1'b1, stat.run_b);
    ce = 1'b1;
    wcyc(3);
    chk("run_b", 1'b0, stat.run_b);
    tsel = 8'h01;
    rsel = 8'h02;
    go(ACC, 16'h01ef);
    arr(1'b0, 1'b1);
    go(RUNS, 16'h01e9);
    arr(1'b0, 1'b1);
    go(RUNS, 16'h01ea);
    arr(1'b1, 1'b1);
    go(RUNS, 16'h0208);
    arr(1'b1, 1'b1);
    go(RUNS, 16'h0209);
    arr(1'b0, 1'b1);
    go(RUNS, 16'h01f4);
    arr(1'b1, 1'b1);
    // Short excursion is filtered out
    freq = 16'h0212;
    wcyc(P - 1);
    freq = 16'h01f4;
    wcyc(P + 4);
    arr(1'b1, 1'b1);
    // Change shows only after the delay
    freq = 16'h0258;
    wcyc(P);
    chk("csa_b_early", 1'b0, stat.const_speed_arrival_b);
    wcyc(4);
    chk("csa_b_late", 1'b1, stat.const_speed_arrival_b);
    go(RUNS, 16'h01f4);
    go(STP, 16'h01f4);
    arr(1'b0, 1'b0);
    // Distinct, then equal ramp thresholds
    for (int k = 0; k < 2; k++) begin
      prm.decel_off_threshold = (k == 0) ? 16'h00c8 : 16'h012c;
      go(STP, 16'h0000);
      go(ACC, 16'h011c);
      arr(1'b0, 1'b0);
      go(ACC, 16'h011d);
      arr(1'b0, 1'b1);
      go(RUNS, 16'h011d);
      arr(1'b0, 1'b1);
      go(DEC, prm.decel_off_threshold - 16'h0005);
      arr(1'b0, 1'b1);
      go(DEC, prm.decel_off_threshold - 16'h0006);
      arr(1'b0, 1'b0);
      go(DEC, 16'h012c);
      arr(1'b0, 1'b0);
    end
    // Other codes pass the external functions through
    tsel = 8'h05;
    rsel = 8'h05;
    for (int k = 0; k < 2; k++) begin
      text = k[0];
      rext = ~k[0];
      wcyc(3);
      chk("term11_ext", ~k[0], lvl);
      chk("relay_ext", ~k[0], no);
    end
    stop_test();
  end
endmodule
`default_nettype wire
